// ==== include/pwci_defines.vh ====
`ifndef PWCI_DEFINES_VH
`define PWCI_DEFINES_VH

// Register byte offsets on the APB bus
`define PWCI_OFF_DATA      12'h000
`define PWCI_OFF_DIR       12'h004
`define PWCI_OFF_ANALOG    12'h008
`define PWCI_OFF_PULLUP    12'h00C
`define PWCI_OFF_OPTION    12'h010
`define PWCI_OFF_IOC       12'h014
`define PWCI_OFF_INTCTL    12'h018
`define PWCI_OFF_CONTROL   12'h01C

// Field positions
`define PWCI_OPT_PUDIS_BIT  7
`define PWCI_INT_FLAG_BIT   0
`define PWCI_INT_GIE_BIT    7
`define PWCI_INT_PERIPHERAL_INTERRUPT_ENABLE_BIT   6
`define PWCI_INT_RBIE_BIT   3
`define PWCI_CTL_SLEEP_BIT  0

// Reset values
`define PWCI_RST_DIR       8'hFF
`define PWCI_RST_ANALOG    8'hFF
`define PWCI_RST_PULLUP    8'hFF
`define PWCI_RST_OPTION    8'hFF
`define PWCI_RST_IOC       8'h00
`define PWCI_RST_ZERO8     8'h00

`endif

// ==== src/pwci_port.v ====
`timescale 1ns/100ps
// Contract
// - Eight pins, each input or output, under an eight-bit direction register.
// - Direction bit 1 turns the pin driver off, pin is an input.
// - Direction bit 0 drives the pin from its output latch bit.
// - Data read returns pin levels; data write updates the output latch.
// - Every port write stores the written data, not sampled pin levels, with analog-selected bits zeroed.
// - Direction bits drive outputs even on analog pins; software keeps them set.
// - Analog-selected pins read zero on every digital read.
// - Analog select never affects digital output enable (pin_oe).
// - Read-modify-write stores zero into analog-selected output latch bits.
// - One pull-up enable bit per pin across all eight pins.
// - Pull-up forced off while the pin is an output.
// - Global pull-up disable bit set at power-on keeps all pull-ups off.
// - One change enable bit per pin; all disabled after power-on reset.
// - Enabled pins compared with last-read latch; mismatches ORed into change flag.
// - A pending change condition wakes the device from sleep.
// - Mismatch keeps setting the flag; port access ends it, then flag cleared.
// - Last-read latch survives external-pin and brown-out resets.
// - Change in the same cycle as a port read still sets the flag.
// - Flag sets regardless of global, peripheral or RBIE enables; per-pin change enables gate it.
`include "pwci_defines.vh"

module pwci_port #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             por_n,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_out,
    output reg  [WIDTH-1:0] pin_oe,
    output reg  [WIDTH-1:0] pullup_on,
    output reg              change_interrupt_flag,
    output reg              change_irq,
    output reg              wake
);

    reg  [WIDTH-1:0] sync_a;
    reg  [WIDTH-1:0] sync_b;
    reg  [WIDTH-1:0] out_latch;
    reg  [WIDTH-1:0] pin_direction_bits;
    reg  [WIDTH-1:0] analog_select_bits;
    reg  [WIDTH-1:0] pullup_enable_bits;
    reg  [7:0]       option_reg;
    reg  [WIDTH-1:0] change_interrupt_enable_bits;
    reg  [WIDTH-1:0] last_read;
    reg              global_interrupt_enable;
    reg              peripheral_interrupt_enable;
    reg              change_int_enable;
    reg              sleep_mode;
    reg  [31:0]      next_prdata;
    reg              next_err;

    wire             access;
    wire             wr;
    wire             rd;
    wire             data_hit;
    wire [WIDTH-1:0] digital_in;
    wire [WIDTH-1:0] mismatch;
    wire             any_mismatch;
    wire [7:0]       intctl_view;

    // Zero-extend an eight-bit field into a bus word
    function [31:0] pwci_word;
        input [7:0] v;
        begin
            pwci_word = {24'h000000, v};
        end
    endfunction

    // Read-modify-write merge: analog-selected pins read as zero, so their latch bits store zero
    function [WIDTH-1:0] pwci_rmw;
        input [WIDTH-1:0] wdata;
        input [WIDTH-1:0] amask;
        begin
            pwci_rmw = wdata & ~amask;
        end
    endfunction

    assign access       = psel & penable & pready;
    assign wr           = access & pwrite;
    assign rd           = access & ~pwrite;
    assign data_hit     = (paddr == `PWCI_OFF_DATA);
    assign digital_in   = sync_b & ~analog_select_bits;
    assign mismatch     = (digital_in ^ last_read) & change_interrupt_enable_bits;
    assign any_mismatch = |mismatch;
    assign intctl_view  = {global_interrupt_enable, peripheral_interrupt_enable, 2'b00,
                           change_int_enable, 2'b00, change_interrupt_flag};

    // Two-flop pin synchroniser
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= `PWCI_RST_ZERO8;
            sync_b <= `PWCI_RST_ZERO8;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    // Last-read latch: only a power-on reset clears it
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            last_read <= `PWCI_RST_ZERO8;
        end else if (presetn && (rd || wr) && data_hit) begin
            last_read <= digital_in;
        end
    end

    // Configuration registers written over the bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_latch                    <= `PWCI_RST_ZERO8;
            pin_direction_bits           <= `PWCI_RST_DIR;
            analog_select_bits           <= `PWCI_RST_ANALOG;
            pullup_enable_bits           <= `PWCI_RST_PULLUP;
            option_reg                   <= `PWCI_RST_OPTION;
            change_interrupt_enable_bits <= `PWCI_RST_IOC;
            global_interrupt_enable      <= 1'b0;
            peripheral_interrupt_enable  <= 1'b0;
            change_int_enable            <= 1'b0;
            sleep_mode                   <= 1'b0;
        end else begin
            if (wr && data_hit) begin
                out_latch <= pwci_rmw(pwdata[WIDTH-1:0], analog_select_bits);
            end else if (wr && paddr == `PWCI_OFF_DIR) begin
                pin_direction_bits <= pwdata[WIDTH-1:0];
            end else if (wr && paddr == `PWCI_OFF_ANALOG) begin
                analog_select_bits <= pwdata[WIDTH-1:0];
            end else if (wr && paddr == `PWCI_OFF_PULLUP) begin
                pullup_enable_bits <= pwdata[WIDTH-1:0];
            end else if (wr && paddr == `PWCI_OFF_OPTION) begin
                option_reg <= pwdata[7:0];
            end else if (wr && paddr == `PWCI_OFF_IOC) begin
                change_interrupt_enable_bits <= pwdata[WIDTH-1:0];
            end else if (wr && paddr == `PWCI_OFF_INTCTL) begin
                global_interrupt_enable     <= pwdata[`PWCI_INT_GIE_BIT];
                peripheral_interrupt_enable <= pwdata[`PWCI_INT_PERIPHERAL_INTERRUPT_ENABLE_BIT];
                change_int_enable           <= pwdata[`PWCI_INT_RBIE_BIT];
            end else if (wr && paddr == `PWCI_OFF_CONTROL) begin
                sleep_mode <= pwdata[`PWCI_CTL_SLEEP_BIT];
            end
            if (sleep_mode && any_mismatch) begin
                sleep_mode <= 1'b0;
            end
        end
    end

    // Change flag: mismatch sets it and wins over a software clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_interrupt_flag <= 1'b0;
        end else if (any_mismatch) begin
            change_interrupt_flag <= 1'b1;
        end else if (wr && paddr == `PWCI_OFF_INTCTL && !pwdata[`PWCI_INT_FLAG_BIT]) begin
            change_interrupt_flag <= 1'b0;
        end
    end

    // Pin drivers, pull-ups, interrupt request and wake
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out    <= `PWCI_RST_ZERO8;
            pin_oe     <= `PWCI_RST_ZERO8;
            pullup_on  <= `PWCI_RST_ZERO8;
            change_irq <= 1'b0;
            wake       <= 1'b0;
        end else begin
            pin_out    <= out_latch;
            pin_oe     <= ~pin_direction_bits;
            pullup_on  <= pullup_enable_bits & pin_direction_bits
                          & {WIDTH{~option_reg[`PWCI_OPT_PUDIS_BIT]}};
            change_irq <= change_interrupt_flag & change_int_enable
                          & global_interrupt_enable;
            wake       <= sleep_mode & (any_mismatch | (change_interrupt_flag & change_int_enable));
        end
    end

    // APB read mux and unmapped-address error
    always @* begin
        next_prdata = 32'h00000000;
        next_err    = 1'b0;
        if (paddr == `PWCI_OFF_DATA) begin
            next_prdata = pwci_word(digital_in);
        end else if (paddr == `PWCI_OFF_DIR) begin
            next_prdata = pwci_word(pin_direction_bits);
        end else if (paddr == `PWCI_OFF_ANALOG) begin
            next_prdata = pwci_word(analog_select_bits);
        end else if (paddr == `PWCI_OFF_PULLUP) begin
            next_prdata = pwci_word(pullup_enable_bits);
        end else if (paddr == `PWCI_OFF_OPTION) begin
            next_prdata = pwci_word(option_reg);
        end else if (paddr == `PWCI_OFF_IOC) begin
            next_prdata = pwci_word(change_interrupt_enable_bits);
        end else if (paddr == `PWCI_OFF_INTCTL) begin
            next_prdata = pwci_word(intctl_view);
        end else if (paddr == `PWCI_OFF_CONTROL) begin
            next_prdata = {31'h00000000, sleep_mode};
        end else begin
            next_err = 1'b1;
        end
    end

    // APB slave: one wait state, answer registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= next_err;
            prdata  <= pwrite ? 32'h00000000 : next_prdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
    end

endmodule // pwci_port

// ==== tb/pwci_port_checker.sv ====
`timescale 1ns/100ps
module pwci_port_checker #(
    parameter WIDTH = 8
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [WIDTH-1:0] pin_oe,
    input wire logic [WIDTH-1:0] pullup_on,
    input wire logic             change_interrupt_flag,
    input wire logic             change_irq,
    input wire logic             wake
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus handshake, pin safety and change flag relations
    property p_pu_out; (pullup_on & pin_oe) == 0; endproperty
    a_pu_out: assert property (p_pu_out) else $error("pull-up on a driven pin");
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no answer after one wait");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than a cycle");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside a transfer");
    property p_hold; change_interrupt_flag && !(psel && pwrite) |=> change_interrupt_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped without a write");
    property p_irq; change_irq |-> $past(change_interrupt_flag); endproperty
    a_irq: assert property (p_irq) else $error("request without flag");
    property p_rst; $rose(presetn) |-> pullup_on == 0 && pin_oe == 0; endproperty
    a_rst: assert property (p_rst) else $error("pins active after reset");
    // Main scenarios reached
    c_flag: cover property (change_interrupt_flag);
    c_err: cover property (pslverr);
    c_wake: cover property (wake);
endmodule // pwci_port_checker

bind pwci_port pwci_port_checker #(.WIDTH(WIDTH)) pwci_port_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .change_interrupt_flag(change_interrupt_flag),
    .change_irq(change_irq), .wake(wake));

// ==== tb/pwci_pins.sv ====
`timescale 1ns/100ps
module pwci_pins (
    input wire logic       pclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic     [7:0] level
);
    logic [7:0] flt = 8'h55;
    // A floating pin wanders every cycle
    always @(posedge pclk) flt <= ~flt;
    // Pin level: port driver, board driver, pull-up, else floating
    always_comb for (int i = 0; i < 8; i++)
        level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pullup_on[i] ? 1'b1 : flt[i];
endmodule // pwci_pins

// ==== tb/tb_port_with_change_interrupt.sv ====
`timescale 1ns/100ps
`include "pwci_defines.vh"
module tb_port_with_change_interrupt;
    logic        pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, w;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, flag, irq, wake;
    logic [7:0]  lvl, pin_out, pin_oe, pullup_on, ext = 8'h00, d, v, e;
    logic [32:0] q[$];
    integer      seed = 32'haffa, mismatches = 0, compares = 0, cyc = 0;
    pwci_port #(.WIDTH(8)) pwci_port_i (.pclk(pclk), .presetn(presetn), .por_n(por_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(lvl),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .change_interrupt_flag(flag), .change_irq(irq), .wake(wake));
    pwci_pins pwci_pins_i (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .ext_val(ext), .ext_en(8'hFF), .level(lvl));
    // Clock and hang guard
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            stop_test;
        end
    end
    task stop_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [32:0] s, input logic [32:0] x);
        compares++;
        if (s !== x) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask
    // One APB transfer: setup, then access until ready
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] dt);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, dt};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] x, input logic er);
        q.push_back({er, 24'h0, x});
        apb(0, a, 8'h00);
    endtask
    // Read results taken off the queue as they appear
    always @(posedge pclk) if (pready && !pwrite && q.size() > 0)
        chk("read", {pslverr, prdata}, q.pop_front());
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        por_n <= 1;
        rd(`PWCI_OFF_DIR, 8'hFF, 0);
        rd(`PWCI_OFF_ANALOG, 8'hFF, 0);
        rd(`PWCI_OFF_PULLUP, 8'hFF, 0);
        rd(`PWCI_OFF_OPTION, 8'hFF, 0);
        rd(`PWCI_OFF_IOC, 8'h00, 0);
        rd(12'h020, 8'h00, 1);
        v = 8'($random(seed));
        d = 8'($random(seed));
        ext <= v;
        repeat (4) @(posedge pclk);
        rd(`PWCI_OFF_DATA, 8'h00, 0);
        chk("pullups", pullup_on, 8'h00);
        apb(1, `PWCI_OFF_ANALOG, 8'h00);
        rd(`PWCI_OFF_DATA, v, 0);
        apb(1, `PWCI_OFF_DATA, d);
        apb(1, `PWCI_OFF_DIR, 8'h0F);
        apb(1, `PWCI_OFF_ANALOG, 8'h30);
        apb(1, `PWCI_OFF_OPTION, 8'h00);
        repeat (2) @(posedge pclk);
        chk("drivers", pin_oe, 8'hF0);
        chk("latch", pin_out, d);
        chk("pullups", pullup_on, 8'h0F);
        e = ((d & 8'hF0) | (v & 8'h0F)) & 8'hCF;
        rd(`PWCI_OFF_DATA, e, 0);
        apb(1, `PWCI_OFF_DATA, d);
        repeat (2) @(posedge pclk);
        chk("rmw", pin_out, d & 8'hCF);
        apb(1, `PWCI_OFF_DIR, 8'hFF);
        apb(1, `PWCI_OFF_ANALOG, 8'h00);
        apb(1, `PWCI_OFF_IOC, 8'hFF);
        apb(1, `PWCI_OFF_INTCTL, 8'h88);
        rd(`PWCI_OFF_DATA, v, 0);
        ext <= ~v;
        repeat (5) @(posedge pclk);
        chk("flag", flag, 1);
        chk("irq", irq, 1);
        apb(1, `PWCI_OFF_INTCTL, 8'h88);
        repeat (2) @(posedge pclk);
        chk("flag", flag, 1);
        rd(`PWCI_OFF_DATA, ~v, 0);
        apb(1, `PWCI_OFF_INTCTL, 8'h88);
        repeat (2) @(posedge pclk);
        chk("flag", flag, 0);
        apb(1, `PWCI_OFF_INTCTL, 8'h00);
        ext <= v;
        repeat (5) @(posedge pclk);
        chk("flag", flag, 1);
        chk("irq", irq, 0);
        rd(`PWCI_OFF_DATA, v, 0);
        apb(1, `PWCI_OFF_INTCTL, 8'h00);
        apb(1, `PWCI_OFF_CONTROL, 8'h01);
        ext <= ~v;
        w = 0;
        repeat (8) @(posedge pclk) if (wake === 1'b1) w = 1;
        chk("wake", w, 1);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        apb(1, `PWCI_OFF_ANALOG, 8'h00);
        apb(1, `PWCI_OFF_IOC, 8'hFF);
        repeat (5) @(posedge pclk);
        chk("flag", flag, 1);
        stop_test;
    end
endmodule // tb_port_with_change_interrupt
